/* rtl/ckc_ctrl.sv */
// Purpose: Clock source, division, stop and wait control with APB access
// Assumes: Main oscillator activity arrives as an async pin, synchronised here; on-chip tick is clock-aligned
// Notes: Internal clock is an enable; held high level shown on phi_o
`timescale 1ns/1ns
module ckc_ctrl
   import ckc_pkg::*;
#(
   parameter int OSD_LIMIT = CKC_OSD_LIMIT
)
(
   // Clock and reset
   input wire logic mclk_i,
   input wire logic rst_i,
   // APB slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // Oscillator pins and ticks
   input wire logic main_osc_input_pin_i,
   input wire logic onchip_tick_i,
   output logic main_osc_output_pin_o,
   output logic main_osc_run_o,
   output logic onchip_osc_run_o,
   // CPU side
   input wire logic stop_instruction_i,
   input wire logic wait_instruction_i,
   input wire logic wake_irq_i,
   output logic phi_o,
   output logic phi_en_o,
   output logic osc_stop_reset_o,
   output logic irq_o
);
   // ----------------------------------------
   // Oscillator input synchroniser and tick
   // ----------------------------------------
   logic sync1_reg, sync2_reg, sync3_reg;
   logic main_tick;

   always_ff @(posedge mclk_i)
   begin
      if (rst_i)
      begin
         sync1_reg <= 1'b0;
         sync2_reg <= 1'b0;
         sync3_reg <= 1'b0;
      end
      else
      begin
         sync1_reg <= main_osc_input_pin_i;
         sync2_reg <= sync1_reg;
         sync3_reg <= sync2_reg;
      end
   end

   assign main_tick = sync2_reg & ~sync3_reg;

   // ----------------------------------------
   // Registers and state
   // ----------------------------------------
   logic [7:0] mode_reg, mode_next, misc_reg, misc_next;
   logic [7:0] t1_reg, t1_next, ps1_reg, ps1_next;
   logic [2:0] stat_reg, stat_next, mask_reg, mask_next;
   logic locked_reg, locked_next;
   ckc_state_e state_reg, state_next;
   logic [3:0] d16_reg, d16_next;
   logic [7:0] osd_reg, osd_next;
   logic osd_rst_reg, osd_rst_next;
   logic [31:0] rdata_reg, rdata_next;
   logic err_reg, err_next;
   ckc_apb_req_s req;
   logic wr, rd, sel_clk, tick_sel, run_tick, phi_en;
   logic tim_load, tim_en, uflow;
   logic [7:0] tim_ps, tim_t;
   logic [2:0] ev;
   ckc_div_e div;

   assign req = '{addr: paddr_i, write: pwrite_i, wdata: pwdata_i,
      access: psel_i & penable_i};
   assign wr = req.access & req.write;
   assign rd = req.access & ~req.write;
   assign div = ckc_div_e'(mode_reg[CKC_MODE_DIV_LO +: 2]);
   assign sel_clk = mode_reg[CKC_MODE_OSCSEL];

   // Ceramic/RC selected only after bit 5 is set
   assign tick_sel = sel_clk ? main_tick : onchip_tick_i;
   assign run_tick = tick_sel & (state_reg == CKC_RUN);

   ckc_divider u_div (
      .mclk_i(mclk_i),
      .rst_i(rst_i),
      .main_tick_i(run_tick),
      .div_i(div),
      .phi_en_o(phi_en)
   );

   ckc_timer1 u_tim (
      .mclk_i(mclk_i),
      .rst_i(rst_i),
      .count_en_i(tim_en),
      .load_i(tim_load),
      .ps_load_i(ps1_next),
      .t_load_i(t1_next),
      .ps_o(tim_ps),
      .t_o(tim_t),
      .uflow_o(uflow)
   );

   // ----------------------------------------
   // Next-state logic
   // ----------------------------------------
   always_comb
   begin
      mode_next = mode_reg;
      misc_next = misc_reg;
      t1_next = t1_reg;
      ps1_next = ps1_reg;
      mask_next = mask_reg;
      locked_next = locked_reg;
      state_next = state_reg;
      d16_next = d16_reg;
      osd_next = osd_reg;
      osd_rst_next = 1'b0;
      rdata_next = rdata_reg;
      err_next = 1'b0;
      tim_load = wr && (req.addr == CKC_OFF_T1 || req.addr == CKC_OFF_PS1);
      tim_en = 1'b0;
      ev = 3'b000;
      // Register writes
      if (wr)
      begin
         case (req.addr)
            CKC_OFF_MODE:
            begin
               if (locked_reg)
                  mode_next = (mode_reg & CKC_LOCK_MASK) |
                     (req.wdata[7:0] & ~CKC_LOCK_MASK);
               else
               begin
                  mode_next = req.wdata[7:0];
                  locked_next = 1'b1;
                  ev[CKC_EV_LOCK] = 1'b1;
               end
            end
            CKC_OFF_MISC: misc_next = {misc_reg[7:3],
               misc_reg[CKC_MISC_OSD_FLAG], req.wdata[1:0]};
            CKC_OFF_T1: t1_next = req.wdata[7:0];
            CKC_OFF_PS1: ps1_next = req.wdata[7:0];
            CKC_OFF_MASK: mask_next = req.wdata[2:0];
            CKC_OFF_CMD:
            begin
               if (req.wdata[CKC_CMD_RMW] && !locked_reg)
               begin
                  locked_next = 1'b1;
                  ev[CKC_EV_LOCK] = 1'b1;
               end
            end
            default: ;
         endcase
      end
      // Read data and error taken in setup, standing at access
      if (psel_i && !penable_i)
      begin
         case (req.addr)
            CKC_OFF_MODE: rdata_next = {24'h0000_00, mode_reg};
            CKC_OFF_MISC: rdata_next = {24'h0000_00, misc_reg};
            CKC_OFF_T1: rdata_next = {24'h0000_00, tim_t};
            CKC_OFF_PS1: rdata_next = {24'h0000_00, tim_ps};
            CKC_OFF_STAT: rdata_next = {29'h0000_0000, stat_reg};
            CKC_OFF_MASK: rdata_next = {29'h0000_0000, mask_reg};
            CKC_OFF_CMD: rdata_next = {29'h0000_0000, 1'b0,
               state_reg};
            default:
            begin
               rdata_next = 32'h0000_0000;
               err_next = 1'b1;
            end
         endcase
      end
      // Power state machine
      case (state_reg)
         CKC_RUN:
         begin
            if (stop_instruction_i)
            begin
               state_next = CKC_STOP;
               d16_next = 4'h0;
               if (!misc_reg[CKC_MISC_STAB_SW])
               begin
                  t1_next = CKC_T1_LOAD;
                  ps1_next = CKC_PS1_LOAD;
               end
               tim_load = 1'b1;
            end
            else if (wait_instruction_i)
               state_next = CKC_WAIT;
         end
         CKC_STOP:
         begin
            if (wake_irq_i)
            begin
               state_next = CKC_RECOVER;
               ev[CKC_EV_WAKE] = 1'b1;
            end
         end
         CKC_RECOVER:
         begin
            if (main_tick)
            begin
               d16_next = d16_reg + 4'h1;
               tim_en = (d16_reg == CKC_STOP_DIV);
            end
            if (uflow)
               state_next = CKC_RUN;
         end
         CKC_WAIT:
         begin
            if (wake_irq_i)
            begin
               state_next = CKC_RUN;
               ev[CKC_EV_WAKE] = 1'b1;
            end
         end
         default: state_next = CKC_RUN;
      endcase
      // Oscillation stop detector, runs on the on-chip ticks
      if (misc_reg[CKC_MISC_OSD_EN] && sel_clk &&
         state_reg != CKC_STOP && !mode_reg[CKC_MODE_ONCHIP_OFF])
      begin
         if (main_tick)
            osd_next = 8'h00;
         else if (onchip_tick_i)
         begin
            if (osd_reg == 8'(OSD_LIMIT - 1))
            begin
               osd_rst_next = 1'b1;
               ev[CKC_EV_OSD] = 1'b1;
               osd_next = 8'h00;
            end
            else
               osd_next = osd_reg + 8'h01;
         end
      end
      else
         osd_next = 8'h00;
      // Sticky status: set wins over the read clear
      stat_next = ((rd && req.addr == CKC_OFF_STAT) ? 3'b000 : stat_reg)
         | ev;
   end

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   always_ff @(posedge mclk_i)
   begin
      if (rst_i)
      begin
         mode_reg <= CKC_MODE_RST;
         locked_reg <= 1'b0;
         t1_reg <= CKC_T1_LOAD;
         ps1_reg <= CKC_PS1_LOAD;
         mask_reg <= 3'b000;
         stat_reg <= 3'b000;
         state_reg <= CKC_RUN;
         d16_reg <= 4'h0;
         osd_reg <= 8'h00;
         osd_rst_reg <= 1'b0;
         rdata_reg <= 32'h0000_0000;
         err_reg <= 1'b0;
      end
      else
      begin
         mode_reg <= mode_next;
         locked_reg <= locked_next;
         t1_reg <= t1_next;
         ps1_reg <= ps1_next;
         mask_reg <= mask_next;
         stat_reg <= stat_next;
         state_reg <= state_next;
         d16_reg <= d16_next;
         osd_reg <= osd_next;
         osd_rst_reg <= osd_rst_next;
         rdata_reg <= rdata_next;
         err_reg <= err_next;
      end
   end

   // Oscillation stop flag survives the reset it causes
   always_ff @(posedge mclk_i)
   begin
      if (osd_rst_reg)
         misc_reg <= CKC_MISC_RST | (8'h01 << CKC_MISC_OSD_FLAG);
      else if (rst_i)
         misc_reg <= CKC_MISC_RST & ~(8'h01 << CKC_MISC_OSD_FLAG) |
            (misc_reg & (8'h01 << CKC_MISC_OSD_FLAG));
      else
         misc_reg <= misc_next;
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign main_osc_run_o = (state_reg != CKC_STOP) &
      ~mode_reg[CKC_MODE_MAIN_OFF];
   assign onchip_osc_run_o = ~mode_reg[CKC_MODE_ONCHIP_OFF];
   assign main_osc_output_pin_o = main_osc_run_o & ~sync2_reg;
   assign phi_en_o = phi_en;
   assign phi_o = (state_reg != CKC_RUN) | ~phi_en;
   assign osc_stop_reset_o = osd_rst_reg;
   assign irq_o = |(stat_reg & mask_reg);
   assign prdata_o = rdata_reg;
   assign pslverr_o = err_reg & pready_o;
   assign pready_o = psel_i & penable_i;
endmodule : ckc_ctrl

/* rtl/ckc_pkg.sv */
// Purpose: Shared constants and types of the clock/stop/wait controller
// Assumes: APB, 32-bit data, one word per register
// Notes: Offsets are byte addresses
package ckc_pkg;
   // ----------------------------------------
   // Register offsets
   // ----------------------------------------
   localparam logic [7:0] CKC_OFF_MODE = 8'h00;
   localparam logic [7:0] CKC_OFF_MISC = 8'h04;
   localparam logic [7:0] CKC_OFF_T1 = 8'h08;
   localparam logic [7:0] CKC_OFF_PS1 = 8'h0C;
   localparam logic [7:0] CKC_OFF_STAT = 8'h10;
   localparam logic [7:0] CKC_OFF_MASK = 8'h14;
   localparam logic [7:0] CKC_OFF_CMD = 8'h18;
   // ----------------------------------------
   // Mode register fields
   // ----------------------------------------
   localparam int CKC_MODE_DIV_LO = 6;
   localparam int CKC_MODE_OSCSEL = 5;
   localparam int CKC_MODE_MAIN_OFF = 4;
   localparam int CKC_MODE_ONCHIP_OFF = 3;
   localparam logic [7:0] CKC_LOCK_MASK = 8'h23;
   localparam logic [7:0] CKC_MODE_RST = 8'h80;
   // ----------------------------------------
   // Misc register fields
   // ----------------------------------------
   localparam int CKC_MISC_STAB_SW = 0;
   localparam int CKC_MISC_OSD_EN = 1;
   localparam int CKC_MISC_OSD_FLAG = 2;
   localparam logic [7:0] CKC_MISC_RST = 8'h00;
   // ----------------------------------------
   // Stabilisation wait and detector values
   // ----------------------------------------
   localparam logic [7:0] CKC_T1_LOAD = 8'h01;
   localparam logic [7:0] CKC_PS1_LOAD = 8'hFF;
   localparam logic [3:0] CKC_STOP_DIV = 4'hF;
   localparam int CKC_OSD_LIMIT = 64;
   // ----------------------------------------
   // Command and status bits
   // ----------------------------------------
   localparam int CKC_CMD_STOP = 0;
   localparam int CKC_CMD_WAIT = 1;
   localparam int CKC_CMD_RMW = 2;
   localparam int CKC_EV_WAKE = 0;
   localparam int CKC_EV_OSD = 1;
   localparam int CKC_EV_LOCK = 2;
   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef enum logic [1:0] {CKC_DIV_DOUBLE, CKC_DIV_HIGH, CKC_DIV_MID,
      CKC_DIV_RSV} ckc_div_e;
   typedef enum logic [1:0] {CKC_RUN, CKC_STOP, CKC_RECOVER,
      CKC_WAIT} ckc_state_e;
   typedef struct packed {
      logic [7:0] addr;
      logic write;
      logic [31:0] wdata;
      logic access;
   } ckc_apb_req_s;
endpackage : ckc_pkg

/* rtl/ckc_divider.sv */
// Purpose: Internal clock enable from the selected oscillator ticks
// Assumes: main_tick_i is a one-cycle pulse per input period
// Notes: Divide ratio 1, 2 or 8
`timescale 1ns/1ns
module ckc_divider
   import ckc_pkg::*;
(
   // Clock and reset
   input wire logic mclk_i,
   input wire logic rst_i,
   // Control
   input wire logic main_tick_i,
   input wire ckc_div_e div_i,
   // Enable out
   output logic phi_en_o
);
   logic [2:0] cnt_reg;
   logic [2:0] cnt_next;
   logic [2:0] last;

   always_comb
   begin
      case (div_i)
         CKC_DIV_DOUBLE: last = 3'd0;
         CKC_DIV_HIGH: last = 3'd1;
         default: last = 3'd7;
      endcase
      cnt_next = cnt_reg;
      phi_en_o = 1'b0;
      if (main_tick_i)
      begin
         if (cnt_reg >= last)
         begin
            cnt_next = 3'd0;
            phi_en_o = 1'b1;
         end
         else
         begin
            cnt_next = cnt_reg + 3'd1;
         end
      end
   end

   always_ff @(posedge mclk_i)
   begin
      if (rst_i)
         cnt_reg <= 3'd0;
      else
         cnt_reg <= cnt_next;
   end
endmodule : ckc_divider

/* rtl/ckc_timer1.sv */
// Purpose: Prescaler 1 and timer 1 used for the stabilisation wait
// Assumes: count_en_i is a one-cycle enable
// Notes: Underflow pulses and reloads from ps_load_i and t_load_i, the software or automatic wait values
`timescale 1ns/1ns
module ckc_timer1
   import ckc_pkg::*;
(
   // Clock and reset
   input wire logic mclk_i,
   input wire logic rst_i,
   // Control
   input wire logic count_en_i,
   input wire logic load_i,
   input wire logic [7:0] ps_load_i,
   input wire logic [7:0] t_load_i,
   // Status
   output logic [7:0] ps_o,
   output logic [7:0] t_o,
   output logic uflow_o
);
   logic [7:0] ps_reg, ps_next, t_reg, t_next;
   logic uf_reg, uf_next;

   always_comb
   begin
      ps_next = ps_reg;
      t_next = t_reg;
      uf_next = 1'b0;
      if (load_i)
      begin
         ps_next = ps_load_i;
         t_next = t_load_i;
      end
      else if (count_en_i)
      begin
         if (ps_reg == 8'h00)
         begin
            ps_next = ps_load_i;
            if (t_reg == 8'h00)
            begin
               t_next = t_load_i;
               uf_next = 1'b1;
            end
            else
            begin
               t_next = t_reg - 8'h01;
            end
         end
         else
         begin
            ps_next = ps_reg - 8'h01;
         end
      end
   end

   always_ff @(posedge mclk_i)
   begin
      if (rst_i)
      begin
         ps_reg <= CKC_PS1_LOAD;
         t_reg <= CKC_T1_LOAD;
         uf_reg <= 1'b0;
      end
      else
      begin
         ps_reg <= ps_next;
         t_reg <= t_next;
         uf_reg <= uf_next;
      end
   end

   assign ps_o = ps_reg;
   assign t_o = t_reg;
   assign uflow_o = uf_reg;
endmodule : ckc_timer1

/* verification/ckc_ctrl_chk.sv */
// Purpose: Port-level assertions for the clock/stop/wait controller
// Assumes: One clock domain, synchronous active-high reset
// Notes: Helper flags follow run, stop and wait from the CPU pulses
`timescale 1ns/1ns
module ckc_ctrl_chk
   import ckc_pkg::*;
#(
   parameter int OSD_LIMIT = CKC_OSD_LIMIT
)
(
   // Clock and reset
   input wire logic mclk_i,
   input wire logic rst_i,
   // APB
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic [7:0] paddr_i,
   input wire logic pready_o,
   input wire logic pslverr_o,
   // Oscillator
   input wire logic main_osc_input_pin_i,
   input wire logic main_osc_run_o,
   input wire logic main_osc_output_pin_o,
   input wire logic onchip_osc_run_o,
   // CPU side
   input wire logic stop_instruction_i,
   input wire logic wait_instruction_i,
   input wire logic wake_irq_i,
   input wire logic phi_o,
   input wire logic phi_en_o,
   input wire logic osc_stop_reset_o
);
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (rst_i);
   // ----------------------------------------
   // Helper state
   // ----------------------------------------
   logic run_reg, stop_reg, wait_reg, pin_reg, go_stop, go_wait;
   logic [15:0] quiet_reg;
   assign go_stop = stop_instruction_i && run_reg;
   assign go_wait = wait_instruction_i && run_reg;
   always_ff @(posedge mclk_i)
   begin
      pin_reg <= main_osc_input_pin_i;
      if (rst_i)
      begin
         run_reg <= 1'b1;
         stop_reg <= 1'b0;
         wait_reg <= 1'b0;
         quiet_reg <= 16'h0000;
      end
      else
      begin
         run_reg <= !(go_stop || go_wait) && (run_reg || phi_en_o);
         stop_reg <= go_stop || (stop_reg && !phi_en_o);
         wait_reg <= go_wait || (wait_reg && !phi_en_o);
         if (pin_reg != main_osc_input_pin_i)
            quiet_reg <= 16'h0000;
         else if (quiet_reg != 16'hFFFF)
            quiet_reg <= quiet_reg + 16'h0001;
      end
   end
   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   a_stop_freeze: assert property (go_stop |=> !main_osc_run_o && phi_o)
      else $error("Stop did not freeze clock and oscillator");
   a_stop_quiet: assert property (go_stop |=> (phi_o && !phi_en_o) [*8])
      else $error("Clock ran during stop");
   a_stop_wake: assert property (stop_reg && wake_irq_i |=> main_osc_run_o)
      else $error("Wake did not restart oscillator");
   a_wait_osc: assert property (go_wait && main_osc_run_o |=>
      (phi_o && main_osc_run_o && !phi_en_o) [*4])
      else $error("Wait did not freeze clock with oscillator on");
   a_wait_wake: assert property (wait_reg && wake_irq_i |-> ##[0:80] phi_en_o)
      else $error("Wait exit was not prompt");
   a_osd_quiet: assert property (osc_stop_reset_o |-> quiet_reg >= OSD_LIMIT)
      else $error("Stop reset while oscillator active");
   a_reset_onchip: assert property ($fell(rst_i) |-> onchip_osc_run_o && main_osc_run_o)
      else $error("Oscillators off after reset");
   a_apb_ready: assert property (psel_i && penable_i |-> pready_o)
      else $error("No ready in access cycle");
   a_bad_addr: assert property (psel_i && penable_i |->
      pslverr_o == (paddr_i > CKC_OFF_CMD || paddr_i[1:0] != 2'b00))
      else $error("Wrong error response");
   a_drive_off: assert property (!main_osc_run_o |-> !main_osc_output_pin_o)
      else $error("Feedback pin driven while oscillator halted");
endmodule : ckc_ctrl_chk

/* verification/ckc_osc_model.sv */
// Purpose: Resonator and on-chip oscillator beside the controller
// Assumes: Main pin asynchronous, on-chip tick clock-aligned
// Notes: Pins stand still while their oscillator is off
`timescale 1ns/1ns
module ckc_osc_model
(
   // Clock
   input wire logic mclk_i,
   // Enables
   input wire logic main_run_i,
   input wire logic onchip_run_i,
   input wire logic break_i,
   // Oscillator outputs
   output logic main_pin_o,
   output logic onchip_tick_o
);
   logic [1:0] div_reg = 2'h0;
   initial main_pin_o = 1'b0;
   // Resonator halts when disabled or broken
   always #21 if (main_run_i && !break_i) main_pin_o = !main_pin_o;
   always @(posedge mclk_i)
   begin
      div_reg <= div_reg + 2'h1;
      onchip_tick_o <= onchip_run_i && div_reg == 2'h3;
   end
endmodule : ckc_osc_model

/* verification/mcu_clock_stop_wait_control_test.sv */
// Purpose: Self-checking bench for the clock/stop/wait controller
// Assumes: Read data and error taken at the access edge
// Notes: Detector limit shortened to keep the run short
`timescale 1ns/1ns
module mcu_clock_stop_wait_control_test
   import ckc_pkg::*;
;
   localparam int OSD_LIMIT = 8;
   typedef struct packed {
      logic wr;
      logic [7:0] addr;
      logic [31:0] data;
      logic [31:0] exp;
      logic err;
   } ckc_row_s;
   logic mclk_i, rst_i, psel, pen, pwr, pready, perr, err, mpin, otick;
   logic mrun, orun, stop_instruction, wt, wake, phi, phen, osr, irq, brk;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, q;
   int bad_count, check_count, ticks, phis, t0, p0, n, r;
   ckc_row_s rows [8];
   ckc_ctrl #(.OSD_LIMIT(OSD_LIMIT)) u_ckc_ctrl (
      .mclk_i(mclk_i), .rst_i(rst_i), .psel_i(psel), .penable_i(pen),
      .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata),
      .prdata_o(prdata), .pready_o(pready), .pslverr_o(perr),
      .main_osc_input_pin_i(mpin), .onchip_tick_i(otick),
      .main_osc_output_pin_o(), .main_osc_run_o(mrun),
      .onchip_osc_run_o(orun), .stop_instruction_i(stop_instruction),
      .wait_instruction_i(wt), .wake_irq_i(wake), .phi_o(phi),
      .phi_en_o(phen), .osc_stop_reset_o(osr), .irq_o(irq));
   ckc_osc_model u_ckc_osc_model (.mclk_i(mclk_i), .main_run_i(mrun),
      .onchip_run_i(orun), .break_i(brk), .main_pin_o(mpin),
      .onchip_tick_o(otick));
   initial
   begin
      mclk_i = 1'b0;
      forever #4 mclk_i = ~mclk_i;
   end
   always @(posedge mpin) ticks++;
   always @(posedge mclk_i) if (phen === 1'b1) phis++;
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic wrap_up;
      if (bad_count == 0 && check_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : wrap_up
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp)
      begin
         bad_count++;
         $display("Error at %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      int k;
      @(posedge mclk_i);
      psel <= 1'b1;
      pen <= 1'b0;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk_i);
      pen <= 1'b1;
      k = 0;
      do
      begin
         @(posedge mclk_i);
         k++;
      end
      while (pready !== 1'b1 && k < 16);
      q = prdata;
      err = perr;
      psel <= 1'b0;
      pen <= 1'b0;
      #1;
      if (k >= 16)
      begin
         bad_count++;
         wrap_up();
      end
   endtask : apb
   task automatic rd(input logic [7:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0000_0000);
      chk(q, x);
   endtask : rd
   task automatic pulse(input logic w);
      @(posedge mclk_i);
      stop_instruction <= !w;
      wt <= w;
      @(posedge mclk_i);
      stop_instruction <= 1'b0;
      wt <= 1'b0;
      #1;
   endtask : pulse
   task automatic wait_hi(input logic sel, input int lim);
      int k;
      k = 0;
      while ((sel ? osr : phen) !== 1'b1 && k < lim)
      begin
         @(posedge mclk_i);
         #1;
         k++;
      end
      if (k >= lim)
      begin
         bad_count++;
         wrap_up();
      end
   endtask : wait_hi
   task automatic do_reset;
      @(posedge mclk_i);
      rst_i <= 1'b1;
      repeat (8) @(posedge mclk_i);
      rst_i <= 1'b0;
      #1;
   endtask : do_reset
   task automatic stop_wake(input int exp);
      t0 = ticks;
      @(posedge mclk_i);
      wake <= 1'b1;
      wait_hi(1'b0, 60000);
      n = ticks - t0;
      chk(32'(n >= exp - 16 && n <= exp + 16), 32'h1);
      @(posedge mclk_i);
      wake <= 1'b0;
      #1;
   endtask : stop_wake
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial
   begin
      {psel, pen, pwr, paddr, pwdata, stop_instruction, wt, wake, brk} = '0;
      rst_i = 1'b1;
      rows[0] = '{1'b0, CKC_OFF_MODE, 32'h0, 32'h0000_0080, 1'b0};
      rows[1] = '{1'b0, CKC_OFF_STAT, 32'h0, 32'h0000_0000, 1'b0};
      rows[2] = '{1'b1, CKC_OFF_MASK, 32'h1, 32'h0000_0000, 1'b0};
      rows[3] = '{1'b0, CKC_OFF_MASK, 32'h0, 32'h0000_0001, 1'b0};
      rows[4] = '{1'b1, CKC_OFF_T1, 32'hA5, 32'h0000_0000, 1'b0};
      rows[5] = '{1'b0, CKC_OFF_T1, 32'h0, 32'h0000_00A5, 1'b0};
      rows[6] = '{1'b0, 8'h1C, 32'h0, 32'h0000_0000, 1'b1};
      rows[7] = '{1'b0, 8'h40, 32'h0, 32'h0000_0000, 1'b1};
      do_reset();
      for (int i = 0; i < 8; i++)
      begin
         apb(rows[i].wr, rows[i].addr, rows[i].data);
         chk(32'(err), 32'(rows[i].err));
         if (!rows[i].wr && !rows[i].err) chk(q, rows[i].exp);
      end
      chk(32'(orun), 32'h1);
      apb(1'b1, CKC_OFF_MODE, 32'h21);
      rd(CKC_OFF_MODE, 32'h0000_0021);
      apb(1'b1, CKC_OFF_MODE, 32'hC2);
      rd(CKC_OFF_MODE, 32'h0000_00E1);
      apb(1'b1, CKC_OFF_MODE, 32'h29);
      chk(32'(orun), 32'h0);
      for (int i = 0; i < 3; i++)
      begin
         r = (i == 0) ? 1 : (i == 1) ? 2 : 8;
         apb(1'b1, CKC_OFF_MODE, {24'h0, i[1:0], 6'h21});
         t0 = ticks;
         p0 = phis;
         repeat (400) @(posedge mclk_i);
         n = (phis - p0) * r - (ticks - t0);
         chk(32'(n <= r + 2 && n >= -r - 2), 32'h1);
      end
      // Stop with automatic wait values
      apb(1'b1, CKC_OFF_MISC, 32'h0);
      pulse(1'b0);
      chk(32'({phi, mrun}), 32'h2);
      rd(CKC_OFF_T1, 32'h0000_0001);
      rd(CKC_OFF_PS1, 32'h0000_00FF);
      stop_wake(8192);
      chk(32'(irq), 32'h1);
      apb(1'b0, CKC_OFF_STAT, 32'h0);
      chk(q & 32'h1, 32'h1);
      chk(32'(irq), 32'h0);
      // Stop with software wait values
      apb(1'b1, CKC_OFF_MISC, 32'h1);
      apb(1'b1, CKC_OFF_T1, 32'h0);
      apb(1'b1, CKC_OFF_PS1, 32'h3);
      pulse(1'b0);
      rd(CKC_OFF_T1, 32'h0000_0000);
      rd(CKC_OFF_PS1, 32'h0000_0003);
      stop_wake(64);
      apb(1'b0, CKC_OFF_STAT, 32'h0);
      apb(1'b1, CKC_OFF_MASK, 32'h0);
      pulse(1'b1);
      p0 = phis;
      repeat (20) @(posedge mclk_i);
      #1;
      chk(32'({phis == p0, phi, mrun}), 32'h7);
      @(posedge mclk_i);
      wake <= 1'b1;
      wait_hi(1'b0, 100);
      @(posedge mclk_i);
      wake <= 1'b0;
      #1;
      chk(32'(irq), 32'h0);
      apb(1'b1, CKC_OFF_MASK, 32'h1);
      chk(32'(irq), 32'h1);
      // Oscillation stop detection
      apb(1'b1, CKC_OFF_MISC, 32'h2);
      @(posedge mclk_i);
      brk <= 1'b1;
      wait_hi(1'b1, 500);
      brk <= 1'b0;
      rd(CKC_OFF_MISC, 32'h0000_0004);
      do_reset();
      apb(1'b0, CKC_OFF_MISC, 32'h0);
      chk(q & 32'h4, 32'h4);
      // Stop left by reset, oscillator held stable
      apb(1'b1, CKC_OFF_MODE, 32'h21);
      pulse(1'b0);
      do_reset();
      wait_hi(1'b0, 200);
      apb(1'b1, CKC_OFF_CMD, 32'h4);
      apb(1'b1, CKC_OFF_MODE, 32'h21);
      rd(CKC_OFF_MODE, 32'h0000_0000);
      wrap_up();
   end
endmodule : mcu_clock_stop_wait_control_test
bind ckc_ctrl ckc_ctrl_chk #(.OSD_LIMIT(OSD_LIMIT)) u_ckc_ctrl_chk (
   .mclk_i(mclk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
   .paddr_i(paddr_i), .pready_o(pready_o), .pslverr_o(pslverr_o),
   .main_osc_input_pin_i(main_osc_input_pin_i),
   .main_osc_run_o(main_osc_run_o), .onchip_osc_run_o(onchip_osc_run_o),
   .main_osc_output_pin_o(main_osc_output_pin_o),
   .stop_instruction_i(stop_instruction_i),
   .wait_instruction_i(wait_instruction_i), .wake_irq_i(wake_irq_i),
   .phi_o(phi_o), .phi_en_o(phi_en_o), .osc_stop_reset_o(osc_stop_reset_o));
